// File: common/spcp_defs.svh
`ifndef SPCP_DEFS_SVH
`define SPCP_DEFS_SVH
`define SPCP_CLK_HZ       10000000
`define SPCP_BASE_HZ      2000000
`define SPCP_RD_VALID_NS  150
`define SPCP_LOC_EVEN     2'h0
`define SPCP_LOC_ODD      2'h1
`define SPCP_LOC_G1       2'h2
`define SPCP_LOC_G2       2'h3
`define SPCP_B_FREEZE     7
`define SPCP_B_ABORT      6
`define SPCP_B_BEGIN      5
`define SPCP_B_ARM        4
`define SPCP_G1_RST       8'hff
`define SPCP_G2_RST       4'hf
`define SPCP_HI_NIBBLE    4'hf
`define SPCP_MODE_NORMAL  2'h1
`define SPCP_MODE_SCROLL  2'h2
`define SPCP_MODE_REFRESH 2'h3
`define SPCP_ADDR_STEP    12'h002
`define SPCP_SLOW_THR     21'h002710
`define SPCP_EXT_CODE     3'h7
`endif

// File: common/spcp_pkg.sv
package spcp_pkg;
	typedef enum logic {SPCP_IDLE, SPCP_ACT} spcp_hs_t;
endpackage

// File: core/spcp_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "spcp_defs.svh"
module spcp_port #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          I_MCLK,
	input  wire logic          I_RESET_N,
	// Host port pins
	input  wire logic          I_LOC_SEL1,
	input  wire logic          I_LOC_SEL2,
	input  wire logic          I_READ_N,
	input  wire logic          I_WRITE_N,
	input  wire logic          I_STROBE_HANDSHAKE_IN,
	input  wire logic          I_REMOTE_SELECT_N,
	input  wire logic [DW-1:0] I_DATA,
	output logic      [DW-1:0] O_DATA,
	output logic               O_DATA_OE,
	output logic               O_READY,
	// Front panel and acquisition
	input  wire logic [6:0]    I_PANEL_TIMING,
	input  wire logic [3:0]    I_PANEL_CHMODE,
	input  wire logic          I_HALF_HOLD,
	input  wire logic          I_EXT_CLOCK,
	input  wire logic [DW-1:0] I_ADC_DATA,
	// Instrument controls
	output logic               O_DISPLAY_FREEZE,
	output logic               O_PLOT_LAMP,
	output logic [1:0]         O_PRETRIG,
	output logic [4:0]         O_TB_CODE,
	output logic [1:0]         O_CH_SEL,
	output logic [1:0]         O_RUN_MODE,
	output logic               O_PLOT_START,
	output logic               O_PLOT_ABORT,
	output logic               O_ARM,
	output logic               O_PLOTTING,
	output logic               O_SAMPLE_TICK
);
	localparam int PRE    = `SPCP_CLK_HZ / `SPCP_BASE_HZ;
	localparam int RD_CYC = (`SPCP_RD_VALID_NS * (`SPCP_CLK_HZ / 1000000)) / 1000;
	localparam int SW     = 8 + 2 * DW + 11;

	initial begin
		if (AW != 12 || DW != 8 || PRE < 1 || RD_CYC < 1)
			$error("spcp_port: unsupported width or clock");
	end

	logic [SW-1:0]   s1_r;
	logic [SW-1:0]   s2_r;
	logic            hs_d_r;
	logic            ext_d_r;
	logic            sel1, sel2, rd, wr, hs, remote, ext, hold;
	logic [DW-1:0]   din, adc;
	logic [6:0]      pan_t;
	logic [3:0]      pan_c;
	logic [1:0]      loc;
	logic            hs_fall;

	// Pins cross in through two flops
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			s1_r <= '1;
			s2_r <= '1;
		end else begin
			s1_r <= {I_LOC_SEL1, I_LOC_SEL2, I_READ_N, I_WRITE_N,
				I_STROBE_HANDSHAKE_IN, I_REMOTE_SELECT_N, I_EXT_CLOCK,
				I_HALF_HOLD, I_DATA, I_ADC_DATA, I_PANEL_TIMING, I_PANEL_CHMODE};
			s2_r <= s1_r;
		end
	end

	assign {sel1, sel2} = s2_r[SW-1 -: 2];
	assign rd     = !s2_r[SW-3];
	assign wr     = !s2_r[SW-4];
	assign hs     = s2_r[SW-5];
	assign remote = !s2_r[SW-6];
	assign ext    = s2_r[SW-7];
	assign hold   = s2_r[SW-8];
	assign {din, adc, pan_t, pan_c} = s2_r[SW-9:0];
	assign loc     = {sel1, sel2};
	assign hs_fall = hs_d_r && !hs;

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			hs_d_r  <= 1'b1;
			ext_d_r <= 1'b1;
		end else begin
			hs_d_r  <= hs;
			ext_d_r <= ext;
		end
	end

	// Handshake sequencing
	spcp_pkg::spcp_hs_t hs_st_r;
	logic               act;
	assign act = (hs_st_r == spcp_pkg::SPCP_ACT);

	// ready low from fall to done
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			hs_st_r <= spcp_pkg::SPCP_IDLE;
			O_READY <= 1'b1;
		end else begin
			case (hs_st_r)
				spcp_pkg::SPCP_IDLE: begin
					if (hs_fall) begin
						hs_st_r <= spcp_pkg::SPCP_ACT;
						O_READY <= 1'b0;
					end
				end
				spcp_pkg::SPCP_ACT: begin
					hs_st_r <= spcp_pkg::SPCP_IDLE;
					O_READY <= 1'b1;
				end
				default: begin
					hs_st_r <= spcp_pkg::SPCP_IDLE;
					O_READY <= 1'b1;
				end
			endcase
		end
	end

	logic [7:0] g1_r;
	logic [3:0] g2_r;
	logic       wr_g1, wr_g2, wr_st;
	assign wr_g1 = act && wr && (loc == `SPCP_LOC_G1);
	assign wr_g2 = act && wr && (loc == `SPCP_LOC_G2);
	assign wr_st = act && wr && !sel1;

	// group latches; power-up value is meaningless to the host
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			g1_r <= `SPCP_G1_RST;
			g2_r <= `SPCP_G2_RST;
		end else begin
			if (wr_g1)
				g1_r <= din;
			if (wr_g2)
				g2_r <= din[3:0];
		end
	end

	// actions fire on every low write
	logic go_begin, go_abort, go_arm;
	assign go_begin = wr_g2 && !din[`SPCP_B_BEGIN];
	assign go_abort = wr_g2 && !din[`SPCP_B_ABORT];
	assign go_arm   = wr_g2 && !din[`SPCP_B_ARM];

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_PLOT_START <= 1'b0;
			O_PLOT_ABORT <= 1'b0;
			O_ARM        <= 1'b0;
			O_PLOTTING   <= 1'b0;
		end else begin
			O_PLOT_START <= go_begin;
			O_PLOT_ABORT <= go_abort;
			O_ARM        <= go_arm;
			if (go_abort)
				O_PLOTTING <= 1'b0;
			else if (go_begin)
				O_PLOTTING <= 1'b1;
		end
	end

	logic [6:0] eff_t;
	logic [3:0] eff_c;
	logic       freeze;
	assign eff_t  = remote ? g1_r[6:0] : pan_t;
	assign eff_c  = remote ? g2_r : pan_c;
	// freeze low holds display in remote mode; store access also holds
	assign freeze = (remote && !g1_r[`SPCP_B_FREEZE]) || !sel1;

	function automatic logic [20:0] thr_of(input logic [4:0] c);
		case (c)
			5'h00:   thr_of = 21'h000002;
			5'h10:   thr_of = 21'h000005;
			5'h08:   thr_of = 21'h00000a;
			5'h04:   thr_of = 21'h000014;
			5'h14:   thr_of = 21'h000032;
			5'h0c:   thr_of = 21'h000064;
			5'h02:   thr_of = 21'h0000c8;
			5'h12:   thr_of = 21'h0001f4;
			5'h0a:   thr_of = 21'h0003e8;
			5'h06:   thr_of = 21'h0007d0;
			5'h16:   thr_of = 21'h001388;
			5'h0e:   thr_of = 21'h002710;
			5'h01:   thr_of = 21'h004e20;
			5'h11:   thr_of = 21'h00c350;
			5'h09:   thr_of = 21'h0186a0;
			5'h05:   thr_of = 21'h030d40;
			5'h15:   thr_of = 21'h07a120;
			5'h0d:   thr_of = 21'h0f4240;
			default: thr_of = 21'h000002;
		endcase
	endfunction

	logic [20:0] thr;
	logic        ext_sel, slow;
	assign thr     = thr_of(eff_t[4:0]);
	assign ext_sel = (eff_t[2:0] == `SPCP_EXT_CODE);
	assign slow    = !ext_sel && (thr >= `SPCP_SLOW_THR);

	// Half-step accumulator gives the 2.5 ratio without jitter drift
	logic [2:0]  pre_r;
	logic [20:0] acc_r;
	logic        base;
	assign base = (pre_r == 3'(PRE - 1));

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			pre_r         <= '0;
			acc_r         <= '0;
			O_SAMPLE_TICK <= 1'b0;
		end else begin
			pre_r         <= base ? 3'h0 : pre_r + 3'h1;
			O_SAMPLE_TICK <= 1'b0;
			if (ext_sel) begin
				acc_r         <= '0;
				O_SAMPLE_TICK <= ext && !ext_d_r;
			end else if (base) begin
				if (acc_r + 21'h2 >= thr) begin
					acc_r         <= acc_r + 21'h2 - thr;
					O_SAMPLE_TICK <= 1'b1;
				end else
					acc_r <= acc_r + 21'h2;
			end
		end
	end

	// Instrument control outputs
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_DISPLAY_FREEZE <= 1'b0;
			O_PLOT_LAMP      <= 1'b0;
			O_PRETRIG        <= '0;
			O_TB_CODE        <= '0;
			O_CH_SEL         <= '0;
			O_RUN_MODE       <= `SPCP_MODE_REFRESH;
		end else begin
			O_DISPLAY_FREEZE <= freeze;
			O_PLOT_LAMP      <= freeze;
			O_PRETRIG        <= eff_t[6:5];
			O_TB_CODE        <= eff_t[4:0];
			O_CH_SEL         <= eff_c[3:2];
			if (eff_c[1:0] == `SPCP_MODE_NORMAL && slow)
				O_RUN_MODE <= `SPCP_MODE_REFRESH;
			else
				O_RUN_MODE <= eff_c[1:0];
		end
	end

	// Store: 4096 words
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [AW-1:0] cnt_r;
	logic [AW-1:0] wp_r;
	logic          samp_wr;
	logic          dual;
	assign dual    = (eff_c[3:2] == 2'h3);
	assign samp_wr = O_SAMPLE_TICK && !freeze;

	// select one high while not plotting hands counter back
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N)
			cnt_r <= '0;
		else if (go_abort || (sel1 && !O_PLOTTING))
			cnt_r <= '0;
		else if (act && !sel1)
			cnt_r <= cnt_r + `SPCP_ADDR_STEP;
	end

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N)
			wp_r <= '0;
		else if (samp_wr) begin
			if (hold && !dual)
				wp_r <= {wp_r[AW-1:1] + 11'h1, 1'b0};
			else
				wp_r <= wp_r + 12'h1;
		end
	end

	// host write wins over the sampler
	always_ff @(posedge I_MCLK) begin
		if (wr_st)
			mem[{cnt_r[AW-1:1], sel2}] <= din;
		else if (samp_wr && !(hold && dual && wp_r[0]))
			mem[wp_r] <= adc;
	end

	logic [DW-1:0] rdv;
	always_comb begin
		case (loc)
			// local: freeze reads one, panel values
			`SPCP_LOC_G1: rdv = {!remote || g1_r[`SPCP_B_FREEZE], eff_t};
			`SPCP_LOC_G2: rdv = {`SPCP_HI_NIBBLE, eff_c};
			default:      rdv = mem[{cnt_r[AW-1:1], sel2}];
		endcase
	end

	// data follows read with pin sync delay
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_DATA    <= '0;
			O_DATA_OE <= 1'b0;
		end else begin
			O_DATA    <= rdv;
			O_DATA_OE <= rd;
		end
	end

	property p_rdy_fall;
		@(posedge I_MCLK) disable iff (!I_RESET_N)
		hs_fall && O_READY |=> !O_READY ##1 O_READY;
	endproperty
	a_rdy_fall: assert property (p_rdy_fall) else $error("ready pulse wrong");

	property p_oe;
		@(posedge I_MCLK) disable iff (!I_RESET_N)
		O_DATA_OE |-> $past(rd);
	endproperty
	a_oe: assert property (p_oe) else $error("bus driven without read");

	property p_g2_ones;
		@(posedge I_MCLK) disable iff (!I_RESET_N)
		loc == `SPCP_LOC_G2 |=> O_DATA[7:4] == `SPCP_HI_NIBBLE;
	endproperty
	a_g2_ones: assert property (p_g2_ones) else $error("group two top bits");

	property p_step;
		@(posedge I_MCLK) disable iff (!I_RESET_N)
		act && !sel1 && !go_abort |=> cnt_r == $past(cnt_r) + `SPCP_ADDR_STEP;
	endproperty
	a_step: assert property (p_step) else $error("counter step not two");

	property p_abort;
		@(posedge I_MCLK) disable iff (!I_RESET_N)
		go_abort |=> cnt_r == '0 && !O_PLOTTING && O_PLOT_ABORT;
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not clear");

	property p_idle_clr;
		@(posedge I_MCLK) disable iff (!I_RESET_N)
		sel1 && !O_PLOTTING |=> cnt_r == '0;
	endproperty
	a_idle_clr: assert property (p_idle_clr) else $error("counter not cleared");

	property p_slow;
		@(posedge I_MCLK) disable iff (!I_RESET_N)
		eff_c[1:0] == `SPCP_MODE_NORMAL && slow |=> O_RUN_MODE == `SPCP_MODE_REFRESH;
	endproperty
	a_slow: assert property (p_slow) else $error("slow range ran normal");

	property p_local;
		@(posedge I_MCLK) disable iff (!I_RESET_N)
		loc == `SPCP_LOC_G1 && !remote |=> O_DATA[`SPCP_B_FREEZE];
	endproperty
	a_local: assert property (p_local) else $error("local freeze not one");

	property p_arm;
		@(posedge I_MCLK) disable iff (!I_RESET_N)
		wr_g2 && !din[`SPCP_B_ARM] |=> O_ARM ##1 !O_ARM;
	endproperty
	a_arm: assert property (p_arm) else $error("arm pulse missing");
endmodule
`default_nettype wire

// File: verif/spcp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spcp_host_model (
	// Clock and device outputs
	input  wire logic       i_clk,
	input  wire logic       i_ready,
	input  wire logic       i_oe,
	input  wire logic [7:0] i_data,
	// Controller-driven pins
	output var logic        o_sel1,
	output var logic        o_sel2,
	output var logic        o_read_n,
	output var logic        o_write_n,
	output var logic        o_hs,
	output var logic [7:0]  o_data
);
	int tmo;
	initial begin
		tmo = 0;
		o_sel1 = 1'b1;
		o_sel2 = 1'b0;
		o_read_n = 1'b1;
		o_write_n = 1'b1;
		o_hs = 1'b1;
		o_data = 8'h00;
	end
	task automatic hs(input logic s1, input logic s2);
		int n;
		@(negedge i_clk);
		o_sel1 = s1;
		o_sel2 = s2;
		@(negedge i_clk);
		o_hs = 1'b0;
		n = 0;
		while (i_ready !== 1'b0 && n < 8) begin
			@(negedge i_clk);
			n++;
		end
		while (i_ready !== 1'b1 && n < 8) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 8)
			tmo++;
		o_hs = 1'b1;
		repeat (2) @(negedge i_clk);
	endtask
	task automatic wr(input logic s1, input logic s2, input logic [7:0] d);
		@(negedge i_clk);
		o_write_n = 1'b0;
		o_data = d;
		hs(s1, s2);
		o_write_n = 1'b1;
		// Released bus shows no stale value
		o_data = ~d;
	endtask
	task automatic rd(input logic s1, input logic s2, output logic [7:0] q);
		@(negedge i_clk);
		o_sel1 = s1;
		o_sel2 = s2;
		o_read_n = 1'b0;
		repeat (5) @(negedge i_clk);
		q = (i_oe === 1'b1) ? i_data : 8'hxx;
		o_read_n = 1'b1;
		repeat (4) @(negedge i_clk);
	endtask
endmodule
`default_nettype wire

// File: verif/test_scope_parallel_control_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_scope_parallel_control_port;
	logic       clk, rst_n, rem_n, hhold, extc;
	logic [6:0] ptim;
	logic [3:0] pchm;
	logic [7:0] adc, q;
	wire logic  s1, s2, rd_n, wr_n, hsk, oe, rdy, frz, lamp, pst, pab, arm, plt, tick;
	wire logic [7:0] din, dout;
	wire logic [1:0] pt, chs, rmode;
	wire logic [4:0] tb;
	int fails, total_checks, n_st, n_ab, n_arm, i;
	logic [7:0] mw [3] = '{8'hf9, 8'hfe, 8'hf7};
	logic [1:0] mr [3] = '{2'h1, 2'h2, 2'h3};

	spcp_port uut (.I_MCLK(clk), .I_RESET_N(rst_n), .I_LOC_SEL1(s1), .I_LOC_SEL2(s2),
		.I_READ_N(rd_n), .I_WRITE_N(wr_n), .I_STROBE_HANDSHAKE_IN(hsk),
		.I_REMOTE_SELECT_N(rem_n), .I_DATA(din), .O_DATA(dout), .O_DATA_OE(oe),
		.O_READY(rdy), .I_PANEL_TIMING(ptim), .I_PANEL_CHMODE(pchm), .I_HALF_HOLD(hhold),
		.I_EXT_CLOCK(extc), .I_ADC_DATA(adc), .O_DISPLAY_FREEZE(frz), .O_PLOT_LAMP(lamp),
		.O_PRETRIG(pt), .O_TB_CODE(tb), .O_CH_SEL(chs), .O_RUN_MODE(rmode),
		.O_PLOT_START(pst), .O_PLOT_ABORT(pab), .O_ARM(arm), .O_PLOTTING(plt),
		.O_SAMPLE_TICK(tick));
	spcp_host_model host (.i_clk(clk), .i_ready(rdy), .i_oe(oe), .i_data(dout),
		.o_sel1(s1), .o_sel2(s2), .o_read_n(rd_n), .o_write_n(wr_n), .o_hs(hsk),
		.o_data(din));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		n_st += int'(pst === 1'b1);
		n_ab += int'(pab === 1'b1);
		n_arm += int'(arm === 1'b1);
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic t_init();
		check({7'h0, rdy}, 8'h01);
		// Local mode: panel asks normal at a fast code, so normal runs
		check({6'h0, rmode}, {6'h0, pchm[1:0]});
		// copy local settings before going remote
		host.rd(1'b1, 1'b0, q);
		check(q, {1'b1, ptim});
		host.wr(1'b1, 1'b0, q);
		host.rd(1'b1, 1'b1, q);
		check(q, {4'hf, pchm});
		host.wr(1'b1, 1'b1, q);
		check({7'h0, oe}, 8'h00);
		rem_n = 1'b0;
		$display("test init done");
	endtask
	task automatic t_group1();
		host.wr(1'b1, 1'b0, 8'h45);
		host.rd(1'b1, 1'b0, q);
		check(q, 8'h45);
		check({frz, lamp, pt, 4'h0}, 8'he0);
		check({3'h0, tb}, 8'h05);
		host.wr(1'b1, 1'b0, 8'h80);
		check({frz, lamp, pt, 4'h0}, 8'h00);
		$display("test group1 done");
	endtask
	task automatic t_modes();
		for (i = 0; i < 3; i++) begin
			host.wr(1'b1, 1'b1, mw[i]);
			host.rd(1'b1, 1'b1, q);
			check(q, mw[i]);
			check({chs, 4'h0, rmode}, {mw[i][3:2], 4'h0, mr[i]});
		end
		// Slow code 10000 forces refresh behind a normal readback
		host.wr(1'b1, 1'b0, 8'h8e);
		host.wr(1'b1, 1'b1, 8'hf9);
		host.rd(1'b1, 1'b1, q);
		check(q, 8'hf9);
		check({6'h0, rmode}, 8'h03);
		host.wr(1'b1, 1'b0, 8'h80);
		$display("test modes done");
	endtask
	task automatic t_actions();
		n_st = 0;
		n_ab = 0;
		n_arm = 0;
		host.wr(1'b1, 1'b1, 8'hd9);
		host.wr(1'b1, 1'b1, 8'hd9);
		host.wr(1'b1, 1'b1, 8'he9);
		host.wr(1'b1, 1'b1, 8'he9);
		check(n_st[7:0], 8'h02);
		check(n_arm[7:0], 8'h02);
		check({7'h0, plt}, 8'h01);
		host.wr(1'b1, 1'b1, 8'hb9);
		check(n_ab[7:0], 8'h01);
		check({7'h0, plt}, 8'h00);
		$display("test actions done");
	endtask
	task automatic t_store();
		host.wr(1'b0, 1'b0, 8'h11);
		host.wr(1'b0, 1'b0, 8'h33);
		host.rd(1'b1, 1'b0, q);
		host.wr(1'b0, 1'b1, 8'h5a);
		host.rd(1'b1, 1'b0, q);
		host.rd(1'b0, 1'b0, q);
		check(q, 8'h11);
		host.rd(1'b0, 1'b1, q);
		check(q, 8'h5a);
		host.hs(1'b0, 1'b0);
		host.rd(1'b0, 1'b0, q);
		check(q, 8'h33);
		$display("test store done");
	endtask

	initial begin
		rst_n = 1'b0;
		rem_n = 1'b1;
		hhold = 1'b0;
		extc = 1'b0;
		ptim = 7'h2a;
		pchm = 4'h9;
		adc = 8'hc3;
		fails = 0;
		total_checks = 0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_init();
		t_group1();
		t_modes();
		t_actions();
		t_store();
		check(host.tmo[7:0], 8'h00);
		stop_test();
	end
endmodule
`default_nettype wire
